// ### rcio_pkg.sv
package rcio_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int DEBOUNCE_MS = 5;
    localparam int DONE_PULSE_MS = 40;
    localparam int FLASH_HALF_MS = 250;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * MS_CYCLES;
    localparam int DONE_PULSE_CYCLES = DONE_PULSE_MS * MS_CYCLES;

    localparam int DEB_W = 18;
    localparam int DONE_W = 21;
    localparam int MS_W = 16;
    localparam int ADDR_W = 8;

    // contact input positions in the debounced vector
    localparam int IN_DIODE = 0;
    localparam int IN_FCLR = 1;
    localparam int IN_START = 2;
    localparam int IN_STOP = 3;
    localparam int IN_AIM = 4;
    localparam int IN_REMOTE = 5;
    localparam int IN_SHUT = 6;
    localparam int IN_BEAM1 = 7;
    localparam int N_IN = 10;
    // laser status pins, synchronised only
    localparam int PIN_FAULT = 10;
    localparam int PIN_SHDN_DONE = 11;
    localparam int PIN_CARD_BUSY = 12;
    localparam int N_PIN = 13;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] COOL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h10;

    localparam int CTRL_SW_REMOTE_BIT = 0;
    localparam int CTRL_SHUT_VAR_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam logic [MS_W-1:0] COOL_RESET = 16'h0BB8;

    localparam int IRQ_FAULT = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_COOL_END = 2;
    localparam int IRQ_MODE = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    localparam int ST_DIODE = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_SCAN = 2;
    localparam int ST_COOL = 3;
    localparam int ST_REMOTE = 4;
    localparam int ST_AIM = 5;
    localparam int ST_ARMED = 6;
    localparam int ST_BEAM_LO = 7;
    localparam int ST_SHUT = 9;
    localparam int ST_CARD = 10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DIODE_OFF, DIODE_ON, DIODE_COOL} diode_state_t;

endpackage

// ### remote_control_io_handler.sv
// Summary of operation
// - diode runs while diode-enable contact is closed, stops when it opens
// - closing fault-clear returns the fault output to its no-fault state
// - scan-start closing begins emission and scanning in remote operation
// - scan-stop closing halts emission in remote operation
// - aiming beam on at closing edge, off at opening edge
// - remote-select closed or software remote setting means remote mode; otherwise command inputs ignored
// - start and stop enabled by software remote setting or remote-select input
// - shutter variant: shutter-open input opens shutter and arms emission
// - multi-input variant: beam-select 1 to 3 picks input unit and arms
// - ready indicator flashes throughout cool-down after diode switch-off
// - cool-down duration is a setting supplied for the laser equipment
// - when diode shutdown completes, ready indicator goes out and cool-down ends
// - a fault opens the fault output until a fault clear arrives
// - emission-done output closes for 40 ms after each emission
// - input-acceptable output closed only while remote-select is closed
// - scan-ready held open while scanning or writing the memory card
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
module remote_control_io_handler
    import rcio_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES,
    parameter int DEB_CYC = DEBOUNCE_CYCLES,
    parameter int DONE_CYC = DONE_PULSE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic diode_enable_input_in,
    input wire logic fault_clear_in,
    input wire logic scan_start_in,
    input wire logic scan_stop_in,
    input wire logic aim_beam_in,
    input wire logic remote_select_in,
    input wire logic shutter_open_in,
    input wire logic beam_select1_in,
    input wire logic beam_select2_in,
    input wire logic beam_select3_in,
    input wire logic fault_event_in,
    input wire logic shutdown_done_in,
    input wire logic card_busy_in,
    output logic diode_powered_output_out,
    output logic fault_ok_out,
    output logic emission_out,
    output logic scanning_out,
    output logic aim_beam_out,
    output logic input_ok_out,
    output logic shutter_open_out,
    output logic [1:0] beam_unit_out,
    output logic armed_out,
    output logic ready_ind_out,
    output logic scan_ready_output_out,
    output logic emission_done_out,
    output logic irq_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction

    // ---------------- input conditioning
    wire [N_PIN-1:0] pin_raw = {card_busy_in, shutdown_done_in, fault_event_in,
        beam_select3_in, beam_select2_in, beam_select1_in, shutter_open_in,
        remote_select_in, aim_beam_in, scan_stop_in, scan_start_in, fault_clear_in,
        diode_enable_input_in};
    logic [N_PIN-1:0] sync1_reg;
    logic [N_PIN-1:0] sync2_reg;
    logic [N_IN-1:0] db;
    logic [N_IN-1:0] db_prev_reg;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            db_prev_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            db_prev_reg <= db;
        end
    end

    // a contact must hold its new level for the whole window before it counts
    for (genvar i = 0; i < N_IN; i++) begin : g_deb
        logic [DEB_W-1:0] cnt_reg;
        logic lvl_reg;
        always_ff @(posedge clk_sys_in) begin
            if (sys_rst_in) begin
                cnt_reg <= '0;
                lvl_reg <= 1'b0;
            end else if (sync2_reg[i] == lvl_reg) begin
                cnt_reg <= '0;
            end else if (cnt_reg == DEB_W'(DEB_CYC - 1)) begin
                lvl_reg <= sync2_reg[i];
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
        assign db[i] = lvl_reg;
    end

    // ---------------- registers and state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [MS_W-1:0] cool_ms_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    diode_state_t state_reg;
    logic [MS_W-1:0] cool_left_reg;
    logic [MS_W-1:0] ms_div_reg;
    logic [MS_W-1:0] flash_ms_reg;
    logic flash_reg;
    logic fault_reg;
    logic scanning_reg;
    logic aim_reg;
    logic shut_reg;
    logic [1:0] beam_reg;
    logic remote_prev_reg;
    logic [DONE_W-1:0] done_cnt_reg;
    logic done_reg;

    wire remote_mode = db[IN_REMOTE] | ctrl_reg[CTRL_SW_REMOTE_BIT];
    wire [N_IN-1:0] rise = db & ~db_prev_reg;
    wire [N_IN-1:0] fall = ~db & db_prev_reg;
    wire [N_IN-1:0] cmd_rise = rise & {N_IN{remote_mode}};
    wire [N_IN-1:0] cmd_fall = fall & {N_IN{remote_mode}};
    wire shut_var = ctrl_reg[CTRL_SHUT_VAR_BIT];
    wire fault_pin = sync2_reg[PIN_FAULT];
    wire card_busy = sync2_reg[PIN_CARD_BUSY];
    wire shdn_done = sync2_reg[PIN_SHDN_DONE];
    wire ms_tick = (ms_div_reg == MS_W'(MS_CYC - 1));
    wire armed = shut_var ? shut_reg : (beam_reg != 2'h0);
    wire cool_over = shdn_done | (cool_left_reg == '0);
    wire diode_go_on = remote_mode & db[IN_DIODE] & ~fault_reg;
    wire diode_go_off = remote_mode & ~db[IN_DIODE];
    wire scan_begin = cmd_rise[IN_START] & (state_reg == DIODE_ON) & ~fault_reg & armed;
    wire scan_end = scanning_reg &
        (cmd_rise[IN_STOP] | (state_reg != DIODE_ON) | fault_reg);
    wire [2:0] beam_rise = cmd_rise[IN_BEAM1 +: 3];
    wire [1:0] beam_pick = beam_rise[0] ? 2'h1 : (beam_rise[1] ? 2'h2 : 2'h3);

    // ---------------- bus handshake
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire wr_ctrl = do_write & (aw_addr_reg == CTRL_OFS);
    wire wr_cool = do_write & (aw_addr_reg == COOL_OFS);
    wire wr_mask = do_write & (aw_addr_reg == IRQ_MASK_OFS);
    wire wr_ro = do_write & ((aw_addr_reg == STATUS_OFS) | (aw_addr_reg == IRQ_STAT_OFS));
    wire wr_hit = wr_ctrl | wr_cool | wr_mask | wr_ro;
    wire rd_stat_clr = ar_hs & (s_axi_araddr == IRQ_STAT_OFS);
    wire [31:0] wmerged_ctrl = merge_bytes(32'(ctrl_reg), w_data_reg, w_strb_reg);
    wire [31:0] wmerged_cool = merge_bytes(32'(cool_ms_reg), w_data_reg, w_strb_reg);
    wire [31:0] wmerged_mask = merge_bytes(32'(irq_mask_reg), w_data_reg, w_strb_reg);

    wire [10:0] status_word = {card_busy, shut_reg, beam_reg, armed, aim_reg, remote_mode,
        state_reg == DIODE_COOL, scanning_reg, fault_reg, state_reg == DIODE_ON};
    wire rd_hit = (s_axi_araddr == CTRL_OFS) | (s_axi_araddr == COOL_OFS) |
        (s_axi_araddr == STATUS_OFS) | (s_axi_araddr == IRQ_STAT_OFS) |
        (s_axi_araddr == IRQ_MASK_OFS);
    wire [31:0] rd_sel = (s_axi_araddr == CTRL_OFS) ? 32'(ctrl_reg) :
        (s_axi_araddr == COOL_OFS) ? 32'(cool_ms_reg) :
        (s_axi_araddr == STATUS_OFS) ? 32'(status_word) :
        (s_axi_araddr == IRQ_STAT_OFS) ? 32'(irq_stat_reg) :
        (s_axi_araddr == IRQ_MASK_OFS) ? 32'(irq_mask_reg) : 32'h0000_0000;

    // ---------------- events and interrupt
    wire mode_chg = remote_mode ^ remote_prev_reg;
    wire cool_end = (state_reg == DIODE_COOL) & cool_over;
    wire fault_set = fault_pin & ~fault_reg;
    wire [IRQ_W-1:0] events = {mode_chg, cool_end, scan_end, fault_set};
    // a new event in the clearing read's cycle survives
    wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~{IRQ_W{rd_stat_clr}}) | events;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (aw_hs) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_sel;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= CTRL_RESET;
            cool_ms_reg <= COOL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            irq_stat_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= wmerged_ctrl[CTRL_W-1:0];
            if (wr_cool) cool_ms_reg <= wmerged_cool[MS_W-1:0];
            if (wr_mask) irq_mask_reg <= wmerged_mask[IRQ_W-1:0];
            irq_stat_reg <= irq_stat_next;
            irq_out <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ---------------- diode and cool-down
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_reg <= DIODE_OFF;
            cool_left_reg <= '0;
        end else begin
            case (state_reg)
                DIODE_OFF: if (diode_go_on) state_reg <= DIODE_ON;
                DIODE_ON: begin
                    if (diode_go_off) begin
                        state_reg <= DIODE_COOL;
                        cool_left_reg <= cool_ms_reg;
                    end
                end
                DIODE_COOL: begin
                    if (cool_over) state_reg <= DIODE_OFF;
                    else if (ms_tick) cool_left_reg <= cool_left_reg - 1'b1;
                end
                default: state_reg <= DIODE_OFF;
            endcase
        end
    end

    // shared millisecond divider; flash phase restarts with each cool-down
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ms_div_reg <= '0;
            flash_ms_reg <= '0;
            flash_reg <= 1'b0;
        end else begin
            ms_div_reg <= ms_tick ? '0 : ms_div_reg + 1'b1;
            if (state_reg != DIODE_COOL) begin
                flash_ms_reg <= '0;
                flash_reg <= 1'b1;
            end else if (ms_tick) begin
                if (flash_ms_reg == MS_W'(FLASH_HALF_MS - 1)) begin
                    flash_ms_reg <= '0;
                    flash_reg <= ~flash_reg;
                end else begin
                    flash_ms_reg <= flash_ms_reg + 1'b1;
                end
            end
        end
    end

    // ---------------- commands
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            {fault_reg, scanning_reg, aim_reg, shut_reg, remote_prev_reg} <= '0;
            beam_reg <= 2'h0;
        end else begin
            remote_prev_reg <= remote_mode;
            if (fault_pin) fault_reg <= 1'b1;
            else if (cmd_rise[IN_FCLR]) fault_reg <= 1'b0;
            if (scan_end) scanning_reg <= 1'b0;
            else if (scan_begin) scanning_reg <= 1'b1;
            if (cmd_rise[IN_AIM]) aim_reg <= 1'b1;
            else if (cmd_fall[IN_AIM]) aim_reg <= 1'b0;
            if (!shut_var) shut_reg <= 1'b0;
            else if (remote_mode) shut_reg <= db[IN_SHUT];
            if (shut_var) beam_reg <= 2'h0;
            else if (|beam_rise) beam_reg <= beam_pick;
        end
    end

    // emission-done pulse; a new emission end restarts the full width
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            done_reg <= 1'b0;
            done_cnt_reg <= '0;
        end else if (scan_end) begin
            done_reg <= 1'b1;
            done_cnt_reg <= DONE_W'(DONE_CYC - 1);
        end else if (done_reg) begin
            if (done_cnt_reg == '0) begin
                done_reg <= 1'b0;
            end else begin
                done_cnt_reg <= done_cnt_reg - 1'b1;
            end
        end
    end

    // ---------------- output flops
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            {diode_powered_output_out, fault_ok_out, emission_out, scanning_out} <= '0;
            {aim_beam_out, input_ok_out, shutter_open_out, beam_unit_out, armed_out} <= '0;
            {ready_ind_out, scan_ready_output_out, emission_done_out} <= '0;
        end else begin
            diode_powered_output_out <= (state_reg == DIODE_ON);
            fault_ok_out <= ~fault_reg;
            emission_out <= scanning_reg;
            scanning_out <= scanning_reg;
            aim_beam_out <= aim_reg;
            input_ok_out <= db[IN_REMOTE];
            shutter_open_out <= shut_reg;
            beam_unit_out <= beam_reg;
            armed_out <= armed;
            ready_ind_out <= ((state_reg == DIODE_ON) & ~fault_reg) |
                ((state_reg == DIODE_COOL) & flash_reg);
            scan_ready_output_out <= (state_reg == DIODE_ON) & ~fault_reg &
                ~scanning_reg & ~card_busy;
            emission_done_out <= done_reg;
        end
    end

endmodule

// ### rcio_chk.sv
module rcio_chk
    import rcio_pkg::*;
#(
    parameter int DONE_CYC = DONE_PULSE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic remote_select_in,
    input wire logic fault_event_in,
    input wire logic fault_ok_out,
    input wire logic emission_out,
    input wire logic scanning_out,
    input wire logic input_ok_out,
    input wire logic scan_ready_output_out,
    input wire logic emission_done_out,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // raw run lengths; 14 covers sync, debounce and output flops with margin
    logic [4:0] hi_reg, lo_reg;
    logic [31:0] done_reg;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || !remote_select_in) hi_reg <= 5'h00;
        else if (hi_reg != 5'h1F) hi_reg <= hi_reg + 5'h01;
    end
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || remote_select_in) lo_reg <= 5'h00;
        else if (lo_reg != 5'h1F) lo_reg <= lo_reg + 5'h01;
    end
    always_ff @(posedge clk_sys_in) begin
        done_reg <= emission_done_out ? done_reg + 32'h1 : 32'h0;
    end
    property p_scan_eq;
        scanning_out == emission_out;
    endproperty
    a_scan_eq: assert property (p_scan_eq) else $error("scan and emission differ");
    property p_done_len;
        $fell(emission_done_out) |-> done_reg == DONE_CYC;
    endproperty
    a_done_len: assert property (p_done_len) else $error("done pulse length");
    property p_busy_ready;
        scanning_out && $past(scanning_out) |-> !scan_ready_output_out;
    endproperty
    a_busy_ready: assert property (p_busy_ready) else $error("ready while scanning");
    property p_fault_set;
        fault_event_in [*5] |-> !fault_ok_out;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not shown");
    property p_ok_hi;
        hi_reg >= 5'h0E |-> input_ok_out;
    endproperty
    a_ok_hi: assert property (p_ok_hi) else $error("input ok missing");
    property p_ok_lo;
        lo_reg >= 5'h0E |-> !input_ok_out;
    endproperty
    a_ok_lo: assert property (p_ok_lo) else $error("input ok in local");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule

bind remote_control_io_handler rcio_chk #(.DONE_CYC(DONE_CYC)) u_chk (
    .clk_sys_in, .sys_rst_in, .remote_select_in, .fault_event_in, .fault_ok_out,
    .emission_out, .scanning_out, .input_ok_out, .scan_ready_output_out, .emission_done_out,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp
);

// ### user_panel.sv
module user_panel
    import rcio_pkg::*;
(
    input wire logic clk_in,
    input wire logic [N_IN-1:0] want_in,
    output logic [N_IN-1:0] contact_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [N_IN-1:0] last = '0;
    logic [N_IN-1:0] level = '0;
    logic [1:0] left [N_IN] = '{default: 2'h0};
    assign contact_out = level;
    // chatter shorter than the debounce time, as real contacts do
    always @(posedge clk_in) begin
        for (int i = 0; i < N_IN; i++) begin
            if (want_in[i] != last[i]) begin
                last[i] <= want_in[i];
                left[i] <= 2'h3;
                level[i] <= ~level[i];
            end else if (left[i] != 2'h0) begin
                left[i] <= left[i] - 2'h1;
                level[i] <= (left[i] == 2'h1) ? last[i] : ~level[i];
            end
        end
    end
endmodule

// ### remote_control_io_handler_bench.sv
module remote_control_io_handler_bench
    import rcio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LAT = 16;
    logic clk_sys_in = 1'h0, sys_rst_in = 1'h1;
    logic fault_event_in = 1'h0, shutdown_done_in = 1'h0, card_busy_in = 1'h0;
    logic [N_IN-1:0] want = '0;
    logic [N_IN-1:0] contact;
    logic diode_powered_output_out, fault_ok_out, emission_out, scanning_out, aim_beam_out;
    logic input_ok_out, shutter_open_out, armed_out, ready_ind_out, scan_ready_output_out;
    logic emission_done_out, irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] beam_unit_out, s_axi_bresp, s_axi_rresp, r;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    int miscompares = 0, checks_done = 0;
    always #12.5 clk_sys_in = ~clk_sys_in;
    user_panel u_panel (.clk_in(clk_sys_in), .want_in(want), .contact_out(contact));
    remote_control_io_handler #(.MS_CYC(10), .DEB_CYC(4), .DONE_CYC(20)) DUT (
        .clk_sys_in, .sys_rst_in, .fault_event_in, .shutdown_done_in, .card_busy_in,
        .diode_enable_input_in(contact[IN_DIODE]), .fault_clear_in(contact[IN_FCLR]),
        .scan_start_in(contact[IN_START]), .scan_stop_in(contact[IN_STOP]),
        .aim_beam_in(contact[IN_AIM]), .remote_select_in(contact[IN_REMOTE]),
        .shutter_open_in(contact[IN_SHUT]), .beam_select1_in(contact[IN_BEAM1]),
        .beam_select2_in(contact[IN_BEAM1 + 1]), .beam_select3_in(contact[IN_BEAM1 + 2]),
        .diode_powered_output_out, .fault_ok_out, .emission_out, .scanning_out, .aim_beam_out,
        .input_ok_out, .shutter_open_out, .beam_unit_out, .armed_out, .ready_ind_out,
        .scan_ready_output_out, .emission_done_out, .irq_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // outputs are registered, so the level seen mid-cycle is what the next edge samples
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic aw, wt, ar, fin;
        @(posedge clk_sys_in);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(negedge clk_sys_in);
            aw = s_axi_awready;
            wt = s_axi_wready;
            ar = s_axi_arready;
            fin = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk_sys_in);
            if (aw) s_axi_awvalid <= 1'h0;
            if (wt) s_axi_wvalid <= 1'h0;
            if (ar) s_axi_arvalid <= 1'h0;
        end while (!fin);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(r, RESP_OKAY);
        chk(q, e);
    endtask
    task automatic set(input int i, input logic v);
        want[i] <= v;
        repeat (LAT) @(posedge clk_sys_in);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        chk(fault_ok_out, 1);
        rd(CTRL_OFS, CTRL_RESET);
        rd(COOL_OFS, COOL_RESET);
        rd(IRQ_MASK_OFS, IRQ_MASK_RESET);
        bus(1'h0, 8'h14, 32'h0);
        chk(r, RESP_SLVERR);
        bus(1'h1, IRQ_MASK_OFS, 32'hF);
        set(IN_DIODE, 1'h1);
        chk(diode_powered_output_out, 0);
        chk(input_ok_out, 0);
        set(IN_REMOTE, 1'h1);
        chk(input_ok_out, 1);
        chk(diode_powered_output_out, 1);
        chk(irq_out, 1);
        rd(IRQ_STAT_OFS, 32'h8);
        repeat (2) @(posedge clk_sys_in);
        chk(irq_out, 0);
        for (int i = 0; i < 3; i++) begin
            set(IN_BEAM1 + i, 1'h1);
            chk(beam_unit_out, i + 1);
            chk(armed_out, 1);
            set(IN_BEAM1 + i, 1'h0);
        end
        set(IN_AIM, 1'h1);
        chk(aim_beam_out, 1);
        set(IN_AIM, 1'h0);
        chk(aim_beam_out, 0);
        set(IN_START, 1'h1);
        chk(scanning_out, 1);
        chk(scan_ready_output_out, 0);
        set(IN_START, 1'h0);
        set(IN_STOP, 1'h1);
        chk(emission_out, 0);
        chk(emission_done_out, 1);
        rd(IRQ_STAT_OFS, 32'h2);
        set(IN_STOP, 1'h0);
        chk(scan_ready_output_out, 1);
        card_busy_in <= 1'h1;
        repeat (5) @(posedge clk_sys_in);
        chk(scan_ready_output_out, 0);
        card_busy_in <= 1'h0;
        bus(1'h1, IRQ_MASK_OFS, 32'h0);
        fault_event_in <= 1'h1;
        repeat (5) @(posedge clk_sys_in);
        fault_event_in <= 1'h0;
        set(IN_FCLR, 1'h0);
        chk(fault_ok_out, 0);
        chk(irq_out, 0);
        set(IN_FCLR, 1'h1);
        chk(fault_ok_out, 1);
        set(IN_FCLR, 1'h0);
        rd(IRQ_STAT_OFS, 32'h1);
        bus(1'h1, CTRL_OFS, 32'h2);
        set(IN_REMOTE, 1'h0);
        set(IN_SHUT, 1'h1);
        chk(shutter_open_out, 0);
        set(IN_START, 1'h1);
        chk(scanning_out, 0);
        set(IN_START, 1'h0);
        bus(1'h1, CTRL_OFS, 32'h3);
        set(IN_SHUT, 1'h0);
        set(IN_SHUT, 1'h1);
        chk(armed_out, 1);
        set(IN_START, 1'h1);
        chk(scanning_out, 1);
        set(IN_START, 1'h0);
        set(IN_STOP, 1'h1);
        chk(scanning_out, 0);
        set(IN_STOP, 1'h0);
        bus(1'h1, COOL_OFS, 32'h5);
        set(IN_DIODE, 1'h0);
        chk(diode_powered_output_out, 0);
        chk(ready_ind_out, 1);
        bus(1'h0, STATUS_OFS, 32'h0);
        chk(q[ST_COOL], 1);
        repeat (50) @(posedge clk_sys_in);
        bus(1'h0, STATUS_OFS, 32'h0);
        chk(q[ST_COOL], 0);
        chk(scan_ready_output_out, 0);
        set(IN_DIODE, 1'h1);
        set(IN_DIODE, 1'h0);
        shutdown_done_in <= 1'h1;
        repeat (6) @(posedge clk_sys_in);
        bus(1'h0, STATUS_OFS, 32'h0);
        chk(q[ST_COOL], 0);
        shutdown_done_in <= 1'h0;
        conclude();
    end
endmodule
